/* rtl/pccd_pkg.sv */
// Shared constants and carrier types for the command-block decoder
package pccd_pkg;

  // Command numbers
  localparam logic [15:0] CMD_QRESP_READ = 16'h17DD;
  localparam logic [15:0] CMD_BIT_WRITE = 16'h17DE;
  localparam logic [15:0] CMD_WR_FROM_REG = 16'h17DF;
  localparam logic [15:0] CMD_WR_FROM_IN = 16'h17E0;
  localparam logic [15:0] CMD_WR_FROM_OUT = 16'h17E1;

  // Block word indices (1-based, as numbered in the block)
  localparam int unsigned W_STAT_TYPE = 3;
  localparam int unsigned W_STAT_ADDR = 4;
  localparam int unsigned W_CMD = 7;
  localparam int unsigned W_CPU_ID = 8;
  localparam int unsigned W_TGT_TYPE = 9;
  localparam int unsigned W_TGT_ADDR = 10;
  localparam int unsigned W_LEN = 11;
  localparam int unsigned W_SRC_ADDR = 12;
  localparam int unsigned BLK_WORDS = 12;

  // Bit-write functions
  localparam logic [15:0] BW_SET_IN = 16'h000D;
  localparam logic [15:0] BW_SET_OUT = 16'h000E;
  localparam logic [15:0] BW_CLR_IN = 16'h0011;
  localparam logic [15:0] BW_CLR_OUT = 16'h0012;

  // Write-to-target memory types
  localparam logic [15:0] TGT_REG = 16'h0001;
  localparam logic [15:0] TGT_IN = 16'h0002;
  localparam logic [15:0] TGT_OUT = 16'h0003;

  // Memory type codes
  localparam logic [7:0] MT_REG = 8'h08;
  localparam logic [7:0] MT_AI = 8'h0A;
  localparam logic [7:0] MT_AQ = 8'h0C;
  localparam logic [7:0] MT_IN_BIT = 8'h46;
  localparam logic [7:0] MT_IN_BYTE = 8'h10;
  localparam logic [7:0] MT_OUT_BIT = 8'h48;
  localparam logic [7:0] MT_OUT_BYTE = 8'h12;
  localparam logic [7:0] MT_TMP_BIT = 8'h4A;
  localparam logic [7:0] MT_TMP_BYTE = 8'h14;
  localparam logic [7:0] MT_INT_BIT = 8'h4C;
  localparam logic [7:0] MT_INT_BYTE = 8'h16;
  localparam logic [7:0] MT_SA_BIT = 8'h4E;
  localparam logic [7:0] MT_SA_BYTE = 8'h18;
  localparam logic [7:0] MT_SB_BIT = 8'h50;
  localparam logic [7:0] MT_SB_BYTE = 8'h1A;
  localparam logic [7:0] MT_SC_BIT = 8'h52;
  localparam logic [7:0] MT_SC_BYTE = 8'h1C;
  localparam logic [7:0] MT_SYS_BIT = 8'h54;
  localparam logic [7:0] MT_SYS_BYTE = 8'h1E;
  localparam logic [7:0] MT_GLB_BIT = 8'h56;
  localparam logic [7:0] MT_GLB_BYTE = 8'h38;

  // Status codes
  localparam logic [7:0] ST_OK = 8'h01;
  localparam logic [7:0] ST_ZERO = 8'h00;
  localparam logic [7:0] ST_ILLEGAL = 8'h0B;
  localparam logic [7:0] ST_SVC_ERR = 8'h05;
  localparam logic [7:0] MINOR_BAD_PARAM = 8'hF4;
  localparam logic [7:0] MINOR_NO_PRIV = 8'hFE;
  localparam logic [15:0] QRESP_WORDS = 16'h0002;
  localparam logic [15:0] ONE_WORD = 16'h0001;

  // Area class of a decoded memory type
  typedef enum logic [1:0] {PCCD_U_WORD, PCCD_U_BIT, PCCD_U_BYTE, PCCD_U_NONE} pccd_unit_t;

  // Decoded memory type
  typedef struct packed {
    logic valid;
    logic read_only;
    pccd_unit_t unit;
  } pccd_mtype_t;

  // Request to the serial link engine
  typedef struct packed {
    logic [15:0] cmd;
    logic [15:0] cpu_id;
    logic [15:0] tgt_type;
    logic [15:0] tgt_addr;
    logic [15:0] length;
    logic [15:0] src_addr;
  } pccd_link_req_t;

  // Write into local memory (table fill or status word)
  typedef struct packed {
    logic [7:0] mem_type;
    logic [15:0] addr;
    logic [15:0] data;
  } pccd_mem_wr_t;

  // Completion report from the link engine
  typedef struct packed {
    logic [7:0] minor;
    logic [7:0] major;
  } pccd_status_t;

endpackage

/* rtl/pccd_fifo.sv */
// Parameterised valid/ready FIFO for words fetched from the remote device
`timescale 1ns/1ps
module pccd_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_r];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  a_fifo_bound: assert property (@(posedge clk) disable iff (!arst_n)
    count_r <= (AW+1)'(DEPTH)) else $error("fifo count above depth");

endmodule

/* rtl/pccd_decoder.sv */
// Command-block decoder: parses blocks, drives the link engine, writes results and status
// Function
// - Query-response read stores two words at word 12
// - Bit write: 13/14 set, 17/18 clear
// - Commands 06111-06113 write from register/input/output
// - Write target types: 1 reg, 2 input, 3 output
// - Ignore words 5 and 6; command at 7
// - Status goes to type word 3, address 4 plus 1
// - Word codes 08h, 0Ah, 0Ch recognised
// - Discrete bit/byte code pairs decoded
// - System area read only; global 56h/38h
// - Byte codes count offsets and lengths in bytes; decoder passes addresses and length through unscaled
// - Status word written is never zero
// - Success writes low 1, high 0
// - Failure: major above 1, minor high byte
// - Errors copied into diagnostic status word one
// - Major 01h means success
`timescale 1ns/1ps
module pccd_decoder #(
  parameter int unsigned FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Command block words from the controller CPU, one per cycle
  input wire logic blk_valid,
  output logic blk_ready,
  input wire logic [15:0] blk_word,
  input wire logic blk_last,
  // Request to the serial link engine
  output logic link_req_valid,
  input wire logic link_req_ready,
  output pccd_pkg::pccd_link_req_t link_req,
  // Words fetched from the remote device
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [15:0] rx_data,
  // Completion from the link engine
  input wire logic link_done,
  input wire pccd_pkg::pccd_status_t link_status,
  // Writes into local memory
  output logic mem_wr_valid,
  input wire logic mem_wr_ready,
  output pccd_pkg::pccd_mem_wr_t mem_wr,
  // Unit of the decoded target area and first diagnostic word
  output pccd_pkg::pccd_unit_t tgt_unit,
  output logic [15:0] diag_status_word,
  output logic busy
);

  typedef enum {S_COLLECT, S_CHECK, S_REQ, S_WAIT, S_DRAIN, S_STATUS} pccd_state_t;

  pccd_state_t state_r;
  logic [15:0] blk_r [pccd_pkg::BLK_WORDS+1];
  logic [3:0] widx_r;
  logic [15:0] fill_cnt_r;
  pccd_pkg::pccd_status_t result_r;
  logic [15:0] diag_r;
  logic fifo_valid;
  logic fifo_ready;
  logic [15:0] fifo_data;
  logic cmd_ok;
  pccd_pkg::pccd_status_t check_err;

  // ----------------------------------------------------------------
  // Memory type decode
  // ----------------------------------------------------------------
  function automatic pccd_pkg::pccd_mtype_t decode_mtype(input logic [7:0] code);
    pccd_pkg::pccd_mtype_t m;
    m = '{valid: 1'b1, read_only: 1'b0, unit: pccd_pkg::PCCD_U_NONE};
    case (code)
      pccd_pkg::MT_REG, pccd_pkg::MT_AI, pccd_pkg::MT_AQ: m.unit = pccd_pkg::PCCD_U_WORD;
      pccd_pkg::MT_IN_BIT, pccd_pkg::MT_OUT_BIT, pccd_pkg::MT_TMP_BIT, pccd_pkg::MT_INT_BIT,
      pccd_pkg::MT_SA_BIT, pccd_pkg::MT_SB_BIT, pccd_pkg::MT_SC_BIT: m.unit = pccd_pkg::PCCD_U_BIT;
      pccd_pkg::MT_IN_BYTE, pccd_pkg::MT_OUT_BYTE, pccd_pkg::MT_TMP_BYTE, pccd_pkg::MT_INT_BYTE,
      pccd_pkg::MT_SA_BYTE, pccd_pkg::MT_SB_BYTE, pccd_pkg::MT_SC_BYTE: m.unit = pccd_pkg::PCCD_U_BYTE;
      pccd_pkg::MT_SYS_BIT: begin
        m.unit = pccd_pkg::PCCD_U_BIT;
        m.read_only = 1'b1;
      end
      pccd_pkg::MT_SYS_BYTE: begin
        m.unit = pccd_pkg::PCCD_U_BYTE;
        m.read_only = 1'b1;
      end
      pccd_pkg::MT_GLB_BIT: m.unit = pccd_pkg::PCCD_U_BIT;
      pccd_pkg::MT_GLB_BYTE: m.unit = pccd_pkg::PCCD_U_BYTE;
      default: m.valid = 1'b0;
    endcase
    return m;
  endfunction

  // Maps the bit-write function and write-to-target type to an area unit
  function automatic pccd_pkg::pccd_unit_t tgt_class(input logic [15:0] cmd, input logic [15:0] typ);
    pccd_pkg::pccd_unit_t u;
    u = pccd_pkg::PCCD_U_NONE;
    if (cmd == pccd_pkg::CMD_BIT_WRITE) begin
      if (typ == pccd_pkg::BW_SET_IN || typ == pccd_pkg::BW_SET_OUT ||
          typ == pccd_pkg::BW_CLR_IN || typ == pccd_pkg::BW_CLR_OUT) begin
        u = pccd_pkg::PCCD_U_BIT;
      end
    end else if (cmd == pccd_pkg::CMD_QRESP_READ) begin
      u = pccd_pkg::PCCD_U_WORD;
    end else if (typ == pccd_pkg::TGT_REG) begin
      u = pccd_pkg::PCCD_U_WORD;
    end else if (typ == pccd_pkg::TGT_IN || typ == pccd_pkg::TGT_OUT) begin
      u = pccd_pkg::PCCD_U_BIT;
    end
    return u;
  endfunction

  // ----------------------------------------------------------------
  // Block capture
  // ----------------------------------------------------------------
  assign blk_ready = (state_r == S_COLLECT);

  // Words beyond the block length are dropped; words 5 and 6 are kept but never read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      widx_r <= 4'h1;
      for (int i = 0; i <= pccd_pkg::BLK_WORDS; i++) begin
        blk_r[i] <= 16'h0000;
      end
    end else if (state_r == S_COLLECT && blk_valid) begin
      if (widx_r <= 4'(pccd_pkg::BLK_WORDS)) begin
        blk_r[widx_r] <= blk_word;
      end
      // Index parks one past the block so an over-long block cannot wrap onto word 1
      if (blk_last) begin
        widx_r <= 4'h1;
      end else if (widx_r <= 4'(pccd_pkg::BLK_WORDS)) begin
        widx_r <= widx_r + 4'h1;
      end
    end else if (state_r == S_STATUS && mem_wr_ready) begin
      for (int i = 1; i <= pccd_pkg::BLK_WORDS; i++) begin
        blk_r[i] <= 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Validation
  // ----------------------------------------------------------------
  logic [15:0] cmd_w;
  logic [15:0] typ_w;
  pccd_pkg::pccd_mtype_t stat_mt;
  assign cmd_w = blk_r[pccd_pkg::W_CMD];
  assign typ_w = blk_r[pccd_pkg::W_TGT_TYPE];
  assign stat_mt = decode_mtype(blk_r[pccd_pkg::W_STAT_TYPE][7:0]);
  assign tgt_unit = tgt_class(cmd_w, typ_w);

  always_comb begin
    cmd_ok = 1'b0;
    check_err = '{minor: pccd_pkg::ST_ZERO, major: pccd_pkg::ST_ILLEGAL};
    case (cmd_w)
      pccd_pkg::CMD_QRESP_READ, pccd_pkg::CMD_BIT_WRITE, pccd_pkg::CMD_WR_FROM_REG,
      pccd_pkg::CMD_WR_FROM_IN, pccd_pkg::CMD_WR_FROM_OUT: begin
        if (tgt_unit == pccd_pkg::PCCD_U_NONE) begin
          check_err = '{minor: pccd_pkg::MINOR_BAD_PARAM, major: pccd_pkg::ST_SVC_ERR};
        end else if (!stat_mt.valid || stat_mt.read_only) begin
          check_err = '{minor: pccd_pkg::MINOR_NO_PRIV, major: pccd_pkg::ST_SVC_ERR};
        end else begin
          cmd_ok = 1'b1;
        end
      end
      default: cmd_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= S_COLLECT;
    end else begin
      case (state_r)
        S_COLLECT: begin
          if (blk_valid && blk_last) begin
            state_r <= S_CHECK;
          end
        end
        S_CHECK: state_r <= cmd_ok ? S_REQ : S_STATUS;
        S_REQ: begin
          if (link_req_ready) begin
            state_r <= S_WAIT;
          end
        end
        S_WAIT: if (link_done) begin
          state_r <= (cmd_w == pccd_pkg::CMD_QRESP_READ && link_status.major == pccd_pkg::ST_OK) ?
                     S_DRAIN : S_STATUS;
        end
        S_DRAIN: begin
          if (fill_cnt_r == pccd_pkg::QRESP_WORDS) begin
            state_r <= S_STATUS;
          end
        end
        S_STATUS: begin
          if (mem_wr_ready) begin
            state_r <= S_COLLECT;
          end
        end
        default: state_r <= S_COLLECT;
      endcase
    end
  end

  assign busy = (state_r != S_COLLECT);
  assign link_req_valid = (state_r == S_REQ);
  assign link_req = '{cmd: cmd_w, cpu_id: blk_r[pccd_pkg::W_CPU_ID], tgt_type: typ_w,
                      tgt_addr: blk_r[pccd_pkg::W_TGT_ADDR], length: blk_r[pccd_pkg::W_LEN],
                      src_addr: blk_r[pccd_pkg::W_SRC_ADDR]};

  // ----------------------------------------------------------------
  // Result word and diagnostics
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      result_r <= '{minor: pccd_pkg::ST_ZERO, major: pccd_pkg::ST_OK};
    end else if (state_r == S_CHECK) begin
      if (cmd_ok) begin
        result_r <= '{minor: pccd_pkg::ST_ZERO, major: pccd_pkg::ST_OK};
      end else begin
        result_r <= check_err;
      end
    end else if (state_r == S_WAIT && link_done) begin
      if (link_status.major == pccd_pkg::ST_OK) begin
        result_r <= '{minor: pccd_pkg::ST_ZERO, major: pccd_pkg::ST_OK};
      end else if (link_status.major == pccd_pkg::ST_ZERO) begin
        result_r <= '{minor: link_status.minor, major: pccd_pkg::ST_ILLEGAL};
      end else begin
        result_r <= link_status;
      end
    end
  end

  // Diagnostic word keeps the last error; a success leaves it alone
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      diag_r <= 16'h0000;
    end else if (state_r == S_STATUS && mem_wr_ready && result_r.major != pccd_pkg::ST_OK) begin
      diag_r <= result_r;
    end
  end
  assign diag_status_word = diag_r;

  // ----------------------------------------------------------------
  // Query-response buffering
  // ----------------------------------------------------------------
  pccd_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .in_data(rx_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_data)
  );

  // Surplus fetched words stay queued for the next read; a short fetch stalls the drain
  assign fifo_ready = (state_r == S_DRAIN) && mem_wr_ready && (fill_cnt_r != pccd_pkg::QRESP_WORDS);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fill_cnt_r <= 16'h0000;
    end else if (state_r == S_CHECK) begin
      fill_cnt_r <= 16'h0000;
    end else if (fifo_valid && fifo_ready) begin
      fill_cnt_r <= fill_cnt_r + pccd_pkg::ONE_WORD;
    end
  end

  // Status address is stored minus one, so one is added back
  always_comb begin
    mem_wr_valid = 1'b0;
    mem_wr = '{mem_type: pccd_pkg::MT_REG, addr: 16'h0000, data: 16'h0000};
    if (state_r == S_DRAIN) begin
      mem_wr_valid = fifo_valid && (fill_cnt_r != pccd_pkg::QRESP_WORDS);
      mem_wr = '{mem_type: pccd_pkg::MT_REG, addr: blk_r[pccd_pkg::W_SRC_ADDR] + fill_cnt_r,
                 data: fifo_data};
    end else if (state_r == S_STATUS) begin
      mem_wr_valid = 1'b1;
      mem_wr = '{mem_type: blk_r[pccd_pkg::W_STAT_TYPE][7:0],
                 addr: blk_r[pccd_pkg::W_STAT_ADDR] + pccd_pkg::ONE_WORD, data: result_r};
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_status_write;
    state_r == S_STATUS && mem_wr_valid;
  endsequence

  sequence s_req_stall;
    link_req_valid && !link_req_ready;
  endsequence

  sequence s_wr_stall;
    mem_wr_valid && !mem_wr_ready;
  endsequence

  sequence s_fill_step;
    state_r == S_DRAIN && mem_wr_valid && mem_wr_ready;
  endsequence

  a_status_nonzero: assert property (@(posedge clk) disable iff (!arst_n)
    s_status_write |-> mem_wr.data != 16'h0000) else $error("zero status written");
  a_status_major: assert property (@(posedge clk) disable iff (!arst_n)
    s_status_write and (mem_wr.data[7:0] != pccd_pkg::ST_OK) |-> mem_wr.data[7:0] > pccd_pkg::ST_OK)
    else $error("error major not above one");
  a_status_addr: assert property (@(posedge clk) disable iff (!arst_n)
    s_status_write |-> mem_wr.addr == blk_r[pccd_pkg::W_STAT_ADDR] + 16'h0001) else $error("bad status addr");
  a_reject_notx: assert property (@(posedge clk) disable iff (!arst_n)
    state_r == S_CHECK && !cmd_ok |=> state_r == S_STATUS && !link_req_valid) else $error("reject moved data");
  a_ok_result: assert property (@(posedge clk) disable iff (!arst_n)
    state_r == S_WAIT && link_done && link_status.major == pccd_pkg::ST_OK |=> result_r == 16'h0001)
    else $error("success status wrong");
  a_zero_mapped: assert property (@(posedge clk) disable iff (!arst_n)
    state_r == S_WAIT && link_done && link_status.major == pccd_pkg::ST_ZERO |=> result_r.major == pccd_pkg::ST_ILLEGAL)
    else $error("zero major not remapped");
  a_diag_copy: assert property (@(posedge clk) disable iff (!arst_n)
    s_status_write and (mem_wr_ready && result_r.major != pccd_pkg::ST_OK) |=> diag_r == $past(result_r))
    else $error("diag not copied");
  a_diag_keep: assert property (@(posedge clk) disable iff (!arst_n)
    s_status_write and (result_r.major == pccd_pkg::ST_OK) |=> $stable(diag_r))
    else $error("diag changed on success");
  a_qresp_two: assert property (@(posedge clk) disable iff (!arst_n)
    state_r == S_DRAIN |-> fill_cnt_r <= pccd_pkg::QRESP_WORDS) else $error("too many words");
  a_fill_count: assert property (@(posedge clk) disable iff (!arst_n)
    s_fill_step |=> fill_cnt_r == $past(fill_cnt_r) + pccd_pkg::ONE_WORD) else $error("fill count skipped");
  a_fill_regs: assert property (@(posedge clk) disable iff (!arst_n)
    s_fill_step |-> mem_wr.mem_type == pccd_pkg::MT_REG) else $error("fill not to registers");
  a_sys_ro: assert property (@(posedge clk) disable iff (!arst_n)
    state_r == S_CHECK && stat_mt.read_only |-> !cmd_ok) else $error("read-only area written");
  a_check_req: assert property (@(posedge clk) disable iff (!arst_n)
    state_r == S_CHECK && cmd_ok |=> link_req_valid) else $error("accepted block not sent");
  a_req_hold: assert property (@(posedge clk) disable iff (!arst_n)
    s_req_stall |=> link_req_valid && $stable(link_req)) else $error("link request dropped");
  a_wr_hold: assert property (@(posedge clk) disable iff (!arst_n)
    s_wr_stall |=> mem_wr_valid && $stable(mem_wr)) else $error("memory write dropped");

endmodule

/* sim/pccd_link_model.sv */
// Behavioural serial link engine standing at the decoder's far side
`timescale 1ns/1ps
module pccd_link_model (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Scenario controls
  input wire logic [4:0] cfg_nwords,
  input wire logic [3:0] cfg_wait,
  input wire pccd_pkg::pccd_status_t cfg_status,
  // Request side
  input wire logic link_req_valid,
  output logic link_req_ready,
  // Fetched words
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [15:0] rx_data,
  // Completion
  output logic link_done,
  output pccd_pkg::pccd_status_t link_status
);
  logic [15:0] word_cnt;
  int i;

  // ----------------------------------------
  // Request, fetch and completion sequence
  // ----------------------------------------
  initial begin
    link_req_ready = 1'b0;
    rx_valid = 1'b0;
    rx_data = 16'hFFFF;
    link_done = 1'b0;
    link_status = 16'hFFFF;
    word_cnt = 16'h0000;
    forever begin
      @(negedge clk);
      if (arst_n === 1'b1 && link_req_valid === 1'b1) begin
        repeat (cfg_wait) @(posedge clk);
        @(posedge clk);
        link_req_ready <= 1'b1;
        @(posedge clk);
        link_req_ready <= 1'b0;
        for (i = 0; i < cfg_nwords; i++) begin
          rx_valid <= 1'b1;
          rx_data <= 16'hA000 + word_cnt;
          @(negedge clk);
          while (rx_ready !== 1'b1) @(negedge clk);
          @(posedge clk);
          word_cnt = word_cnt + 16'h0001;
          rx_valid <= 1'b0;
          rx_data <= ~rx_data;
          @(posedge clk);
        end
        // Status is only meaningful in the done cycle; scrambled afterwards
        link_done <= 1'b1;
        link_status <= cfg_status;
        @(posedge clk);
        link_done <= 1'b0;
        link_status <= ~cfg_status;
      end
    end
  end
endmodule

/* sim/tb.sv */
// Self-checking testbench for the command-block decoder
`timescale 1ns/1ps
module tb;
  logic clk, arst_n, blk_valid, blk_ready, blk_last, link_req_valid, link_req_ready;
  logic rx_valid, rx_ready, link_done, mem_wr_valid, mem_wr_ready, busy, full_seen;
  logic [15:0] blk_word, rx_data, diag_status_word, exp_word;
  logic [15:0] blk [1:12];
  logic [4:0] cfg_nwords;
  logic [3:0] cfg_wait;
  pccd_pkg::pccd_link_req_t link_req;
  pccd_pkg::pccd_status_t link_status, cfg_status;
  pccd_pkg::pccd_mem_wr_t mem_wr, w;
  pccd_pkg::pccd_unit_t tgt_unit;
  int failures, num_checks, nreq;

  pccd_decoder #(.FIFO_DEPTH(16)) dut (.clk(clk), .arst_n(arst_n), .blk_valid(blk_valid),
    .blk_ready(blk_ready), .blk_word(blk_word), .blk_last(blk_last), .link_req_valid(link_req_valid),
    .link_req_ready(link_req_ready), .link_req(link_req), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .link_done(link_done), .link_status(link_status), .mem_wr_valid(mem_wr_valid),
    .mem_wr_ready(mem_wr_ready), .mem_wr(mem_wr), .tgt_unit(tgt_unit),
    .diag_status_word(diag_status_word), .busy(busy));

  pccd_link_model peer (.clk(clk), .arst_n(arst_n), .cfg_nwords(cfg_nwords), .cfg_wait(cfg_wait),
    .cfg_status(cfg_status), .link_req_valid(link_req_valid), .link_req_ready(link_req_ready),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .link_done(link_done),
    .link_status(link_status));

  // ----------------------------------------
  // Clock, watchdog and monitors
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    #500000;
    failures++;
    stop_test;
  end

  always @(posedge clk) begin
    if (link_req_valid === 1'b1 && link_req_ready === 1'b1) nreq <= nreq + 1;
    if (arst_n === 1'b1 && rx_ready === 1'b0) full_seen <= 1'b1;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_wr(input pccd_pkg::pccd_mem_wr_t got, input pccd_pkg::pccd_mem_wr_t exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    @(negedge clk);
    while (s !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 2000) chk16({15'h0000, s}, 16'h0001);
  endtask

  task automatic send_blk();
    int i;
    @(posedge clk);
    for (i = 1; i <= 12; i++) begin
      blk_valid <= 1'b1;
      blk_word <= blk[i];
      blk_last <= (i == 12);
      wait_hi(blk_ready);
      @(posedge clk);
    end
    blk_valid <= 1'b0;
    blk_last <= 1'b0;
    blk_word <= ~blk[12];
  endtask

  // Ready held low one cycle after valid so the write must stand
  task automatic take_wr();
    wait_hi(mem_wr_valid);
    w = mem_wr;
    @(posedge clk);
    mem_wr_ready <= 1'b1;
    @(posedge clk);
    mem_wr_ready <= 1'b0;
  endtask

  // Issue one block and judge request, table writes and status word
  task automatic run(input logic [15:0] cmd, input logic [15:0] tt, input logic [15:0] src,
    input logic [7:0] st, input logic [15:0] sts, input int nl, input int nq);
    int n0, k;
    n0 = nreq;
    blk = '{16'h0006, 16'h0000, {8'h00, st}, 16'h0009, 16'hFFFF, 16'hFFFF, cmd, 16'h0019, tt,
      16'h0008, 16'h0010, src};
    send_blk();
    if (nl == 1) begin
      wait_hi(link_req_valid);
      chk16({15'h0000, busy}, 16'h0001);
      chk16(link_req.cmd, cmd);
      chk16(link_req.cpu_id, 16'h0019);
      chk16(link_req.tgt_type, tt);
      chk16(link_req.tgt_addr, 16'h0008);
      chk16(link_req.length, 16'h0010);
      chk16({14'h0000, tgt_unit}, (cmd == pccd_pkg::CMD_QRESP_READ || tt == 16'h0001) ? 16'h0000 : 16'h0001);
    end
    for (k = 0; k < nq; k++) begin
      take_wr();
      chk_wr(w, {pccd_pkg::MT_REG, src + k[15:0], exp_word});
      exp_word = exp_word + 16'h0001;
    end
    take_wr();
    chk_wr(w, {st, 16'h000A, sts});
    chk16({15'h0000, w.data != 16'h0000}, 16'h0001);
    @(negedge clk);
    chk16(16'(nreq - n0), nl[15:0]);
    if (sts !== 16'h0001) chk16(diag_status_word, sts);
  endtask

  task automatic stop_test();
    $display("failures=%0d num_checks=%0d", failures, num_checks);
    if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_qresp();
    cfg_status = 16'h0001;
    cfg_nwords = 5'd2;
    run(pccd_pkg::CMD_QRESP_READ, 16'h0000, 16'h0064, 8'h08, 16'h0001, 1, 2);
  endtask

  task automatic t_bitwrite();
    logic [15:0] fn [4] = '{16'h000D, 16'h000E, 16'h0011, 16'h0012};
    cfg_nwords = 5'd0;
    foreach (fn[i]) run(pccd_pkg::CMD_BIT_WRITE, fn[i], 16'h0001, 8'h08, 16'h0001, 1, 0);
  endtask

  task automatic t_write();
    cfg_wait = 4'd0;
    for (int k = 0; k < 3; k++) begin
      run(pccd_pkg::CMD_WR_FROM_REG + k[15:0], 16'h0001 + k[15:0], 16'h0001, 8'h08, 16'h0001, 1, 0);
    end
  endtask

  task automatic t_mtypes();
    logic [7:0] ok [19] = '{8'h08, 8'h0A, 8'h0C, 8'h46, 8'h10, 8'h48, 8'h12, 8'h4A, 8'h14, 8'h4C,
      8'h16, 8'h4E, 8'h18, 8'h50, 8'h1A, 8'h52, 8'h1C, 8'h56, 8'h38};
    foreach (ok[i]) run(pccd_pkg::CMD_BIT_WRITE, 16'h000D, 16'h0001, ok[i], 16'h0001, 1, 0);
    run(pccd_pkg::CMD_BIT_WRITE, 16'h000D, 16'h0001, 8'h54, 16'hFE05, 0, 0);
    run(pccd_pkg::CMD_BIT_WRITE, 16'h000D, 16'h0001, 8'h1E, 16'hFE05, 0, 0);
  endtask

  task automatic t_errors();
    run(16'h1234, 16'h0001, 16'h0001, 8'h08, 16'h000B, 0, 0);
    run(pccd_pkg::CMD_WR_FROM_REG, 16'h0005, 16'h0001, 8'h08, 16'hF405, 0, 0);
    cfg_status = 16'h030D;
    run(pccd_pkg::CMD_WR_FROM_IN, 16'h0002, 16'h0001, 8'h08, 16'h030D, 1, 0);
    cfg_status = 16'h0000;
    run(pccd_pkg::CMD_BIT_WRITE, 16'h0012, 16'h0001, 8'h08, 16'h000B, 1, 0);
    cfg_status = 16'h0001;
  endtask

  // Fill the fetch buffer until it refuses, then drain it with empty fetches
  task automatic t_fifo();
    cfg_nwords = 5'd16;
    cfg_wait = 4'd5;
    run(pccd_pkg::CMD_QRESP_READ, 16'h0000, 16'h0200, 8'h08, 16'h0001, 1, 2);
    chk16({15'h0000, full_seen}, 16'h0001);
    cfg_nwords = 5'd0;
    repeat (7) run(pccd_pkg::CMD_QRESP_READ, 16'h0000, 16'h0300, 8'h08, 16'h0001, 1, 2);
    chk16({15'h0000, rx_ready}, 16'h0001);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    arst_n = 1'b0;
    blk_valid = 1'b0;
    blk_word = 16'h0000;
    blk_last = 1'b0;
    mem_wr_ready = 1'b0;
    cfg_nwords = 5'd0;
    cfg_wait = 4'd3;
    cfg_status = 16'h0001;
    failures = 0;
    num_checks = 0;
    nreq = 0;
    full_seen = 1'b0;
    exp_word = 16'hA000;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    chk16(diag_status_word, 16'h0000);
    chk16({15'h0000, busy}, 16'h0000);
    t_qresp();
    t_bitwrite();
    t_write();
    t_mtypes();
    t_errors();
    t_fifo();
    stop_test();
  end
endmodule
